// ---- lmm_pkg.sv ----
// Constants, types and state layout of the life and maintenance monitor
// Contract
// - Every 10000 inrush activations lower inrush life 1%
// - Inrush life at 10% sets bit 3, alarm
// - Power-on, undervoltage, device reset count as activations
// - Control capacitor life falls with weighted energization time
// - Control capacitor life below 10% sets bit 0
// - Main capacitor life updates only on completed measurement
// - Measured main life at/below 85% sets bit 1
// - Measure codes 0,1,2,3,8,9; software writes 0/1 only
// - Request 1 measures at power-off, reports 3 later
// - Drive DC onto motor for 1 s
// - Early power return may leave state 2
// - Start or shutoff while measuring ends 8; a fault ends 9
// - Fan at/below 50% sets bit 2, indication
// - Any single slow fan raises fan fault
// - Count whole hours, save hourly, show 100 h units
// - Intervals shorter than one hour are discarded
// - Timer value saturates at 9998, never wraps
// - Writing 0 clears timer 1..9998; ignored at 0
// - Alarm at setpoint 0..9998; 9999 disables
// - Terminal code 95 high, 195 low drives alarm
// - Life alarm when any life condition reached
package lmm_pkg;
   localparam int CLK_KHZ = 40000;
   localparam int DC_INJECT_MS = 1000;
   localparam int DC_INJECT_CYC = DC_INJECT_MS * CLK_KHZ;
   localparam int SEC_MS = 1000;
   localparam int SEC_CYC = SEC_MS * CLK_KHZ;
   localparam logic [11:0] HOUR_SEC = 12'he10;
   localparam logic [6:0] HOURS_PER_UNIT = 7'h64;
   localparam logic [14:0] INRUSH_BLOCK = 15'h2710;
   localparam logic [7:0] PCT_FULL = 8'h64;
   localparam logic [7:0] INRUSH_ALARM_PCT = 8'h0a;
   localparam logic [7:0] CTRL_ALARM_PCT = 8'h0a;
   localparam logic [7:0] MAIN_ALARM_PCT = 8'h55;
   localparam int ST_CTRL = 0;
   localparam int ST_MAIN = 1;
   localparam int ST_FAN = 2;
   localparam int ST_INRUSH = 3;
   localparam logic [13:0] TMR_MAX = 14'h270e;
   localparam logic [13:0] TMR_OFF = 14'h270f;
   localparam logic [7:0] TERM_LIFE_POS = 8'h5a;
   localparam logic [7:0] TERM_LIFE_NEG = 8'hbe;
   localparam logic [7:0] TERM_MAINT_POS = 8'h5f;
   localparam logic [7:0] TERM_MAINT_NEG = 8'hc3;
   localparam logic [7:0] TERM_RESET = 8'h00;
   localparam logic [3:0] MS_IDLE = 4'h0;
   localparam logic [3:0] MS_REQ = 4'h1;
   localparam logic [3:0] MS_MEAS = 4'h2;
   localparam logic [3:0] MS_DONE = 4'h3;
   localparam logic [3:0] MS_FORCED = 4'h8;
   localparam logic [3:0] MS_ERROR = 4'h9;
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_INRUSH = 4'h1;
   localparam logic [3:0] ADDR_CTRL = 4'h2;
   localparam logic [3:0] ADDR_MAIN = 4'h3;
   localparam logic [3:0] ADDR_MEAS = 4'h4;
   localparam logic [3:0] ADDR_HOURS = 4'h5;
   localparam logic [3:0] ADDR_SETP = 4'h6;
   localparam logic [3:0] ADDR_TERM = 4'h7;
   localparam int FAN_COUNT = 2;
   localparam int PIN_PWRON = 0;
   localparam int PIN_UNDERV = 1;
   localparam int PIN_DEVRST = 2;
   localparam int PIN_MAINS = 3;
   localparam int PIN_START = 4;
   localparam int PIN_SHUTOFF = 5;
   localparam int PIN_FAN = 6;
   localparam int PIN_W = PIN_FAN + FAN_COUNT;

   typedef enum logic [5:0] {
      MST_IDLE = 6'h01,
      MST_REQ = 6'h02,
      MST_MEAS = 6'h04,
      MST_DONE = 6'h08,
      MST_FORCED = 6'h10,
      MST_ERROR = 6'h20
   } lmm_meas_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [15:0] wdata;
   } lmm_req_t;

   typedef struct packed {
      logic [13:0] unit;
      logic [6:0] frac;
   } lmm_nvm_t;

   typedef struct packed {
      logic [PIN_W-1:0] sync1;
      logic [PIN_W-1:0] sync2;
      logic [PIN_W-1:0] prev;
      logic [13:0] blk;
      logic [7:0] inrush;
      logic [7:0] ctrl;
      logic [7:0] main;
      logic measured;
      lmm_meas_t ms;
      logic dc_on;
      logic [25:0] dc_cnt;
      logic [25:0] sec_cnt;
      logic [11:0] sec_in_hr;
      lmm_nvm_t tmr;
      logic [13:0] setp;
      logic [7:0] term_func;
      logic save;
      logic [3:0] status;
      logic life;
      logic maint;
      logic term;
      logic [15:0] rdata;
   } lmm_state_t;
endpackage : lmm_pkg

// ---- lmm_monitor.sv ----
// Life indicators, capacitor measurement sequencer and maintenance timer
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module lmm_monitor
   import lmm_pkg::*;
#(
   parameter int DC_CYC = DC_INJECT_CYC,
   parameter int SEC_CYCLES = SEC_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire lmm_req_t req,
   output logic [15:0] rdata,
   input wire logic [PIN_W-1:0] pins,
   input wire logic ctrl_cap_wear_tick,
   input wire logic meas_done,
   input wire logic [7:0] meas_pct,
   input wire logic meas_fault,
   input wire logic nvm_restore,
   input wire lmm_nvm_t nvm_in,
   output logic nvm_save,
   output lmm_nvm_t nvm_out,
   output logic dc_inject_out,
   output logic life_alarm_out,
   output logic maint_timer_alarm_out,
   output logic maint_due_indication,
   output logic fan_fault_indication,
   output logic alarm_terminal_out
);
   lmm_state_t s;
   lmm_state_t next_s;
   logic [PIN_W-1:0] rise;
   logic [1:0] inc;
   logic [14:0] sum;
   logic mains_fall;
   logic abort;
   logic fan_slow;
   logic [3:0] ms_code;

   always_comb begin
      case (s.ms)
         MST_IDLE: ms_code = MS_IDLE;
         MST_REQ: ms_code = MS_REQ;
         MST_MEAS: ms_code = MS_MEAS;
         MST_DONE: ms_code = MS_DONE;
         MST_FORCED: ms_code = MS_FORCED;
         MST_ERROR: ms_code = MS_ERROR;
         default: ms_code = MS_IDLE;
      endcase
   end

   always_comb begin
      next_s = s;
      next_s.sync1 = pins;
      next_s.sync2 = s.sync1;
      next_s.prev = s.sync2;
      next_s.save = 1'b0;
      rise = s.sync2 & ~s.prev;
      mains_fall = s.prev[PIN_MAINS] & ~s.sync2[PIN_MAINS];
      abort = s.sync2[PIN_START] | s.sync2[PIN_SHUTOFF];
      fan_slow = |s.sync2[PIN_FAN +: FAN_COUNT];

      inc = {1'b0, rise[PIN_PWRON]} + {1'b0, rise[PIN_UNDERV]} + {1'b0, rise[PIN_DEVRST]};
      sum = {1'b0, s.blk} + {13'h0000, inc};
      if (sum >= INRUSH_BLOCK) begin
         next_s.blk = 14'(sum - INRUSH_BLOCK);
         if (s.inrush != 8'h00) begin
            next_s.inrush = s.inrush - 8'h01;
         end
      end else begin
         next_s.blk = sum[13:0];
      end

      if (ctrl_cap_wear_tick && s.ctrl != 8'h00) begin
         next_s.ctrl = s.ctrl - 8'h01;
      end

      case (s.ms)
         MST_REQ: begin
            if (mains_fall) begin
               next_s.ms = MST_MEAS;
               next_s.dc_on = 1'b1;
               next_s.dc_cnt = 26'(DC_CYC - 1);
            end
         end
         MST_MEAS: begin
            if (s.dc_on) begin
               if (s.dc_cnt == 26'h0000000) begin
                  next_s.dc_on = 1'b0;
               end else begin
                  next_s.dc_cnt = s.dc_cnt - 26'h0000001;
               end
            end
            if (abort) begin
               next_s.ms = MST_FORCED;
               next_s.dc_on = 1'b0;
            end else if (meas_fault) begin
               next_s.ms = MST_ERROR;
               next_s.dc_on = 1'b0;
            end else if (meas_done) begin
               next_s.ms = MST_DONE;
               next_s.main = meas_pct;
               next_s.measured = 1'b1;
               next_s.dc_on = 1'b0;
            end
         end
         default: begin
         end
      endcase

      // software writes 0 or 1 only
      if (req.wr && req.addr == ADDR_MEAS) begin
         if (req.wdata == {12'h000, MS_IDLE}) begin
            next_s.ms = MST_IDLE;
            next_s.dc_on = 1'b0;
         end else if (req.wdata == {12'h000, MS_REQ}) begin
            next_s.ms = MST_REQ;
            next_s.dc_on = 1'b0;
         end
      end

      // partial hours never reach the counter
      if (s.sec_cnt == 26'(SEC_CYCLES - 1)) begin
         next_s.sec_cnt = 26'h0000000;
         if (s.sec_in_hr == HOUR_SEC - 12'h001) begin
            next_s.sec_in_hr = 12'h000;
            next_s.save = 1'b1;
            if (s.tmr.frac == HOURS_PER_UNIT - 7'h01) begin
               next_s.tmr.frac = 7'h00;
               if (s.tmr.unit < TMR_MAX) begin
                  next_s.tmr.unit = s.tmr.unit + 14'h0001;
               end
            end else begin
               next_s.tmr.frac = s.tmr.frac + 7'h01;
            end
         end else begin
            next_s.sec_in_hr = s.sec_in_hr + 12'h001;
         end
      end else begin
         next_s.sec_cnt = s.sec_cnt + 26'h0000001;
      end

      if (nvm_restore) begin
         next_s.tmr = nvm_in;
      end

      if (req.wr && req.addr == ADDR_HOURS && req.wdata == 16'h0000 &&
          s.tmr.unit != 14'h0000 && s.tmr.unit <= TMR_MAX) begin
         next_s.tmr.unit = 14'h0000;
         next_s.tmr.frac = 7'h00;
      end

      if (req.wr && req.addr == ADDR_SETP && req.wdata <= {2'b00, TMR_OFF}) begin
         next_s.setp = req.wdata[13:0];
      end
      if (req.wr && req.addr == ADDR_TERM) begin
         next_s.term_func = req.wdata[7:0];
      end

      next_s.status[ST_INRUSH] = next_s.inrush <= INRUSH_ALARM_PCT;
      next_s.status[ST_CTRL] = next_s.ctrl < CTRL_ALARM_PCT;
      next_s.status[ST_MAIN] = next_s.measured && next_s.main <= MAIN_ALARM_PCT;
      next_s.status[ST_FAN] = fan_slow;
      next_s.life = |next_s.status;
      next_s.maint = next_s.setp != TMR_OFF && next_s.tmr.unit >= next_s.setp;

      case (next_s.term_func)
         TERM_LIFE_POS: next_s.term = next_s.life;
         TERM_LIFE_NEG: next_s.term = ~next_s.life;
         TERM_MAINT_POS: next_s.term = next_s.maint;
         TERM_MAINT_NEG: next_s.term = ~next_s.maint;
         default: next_s.term = 1'b0;
      endcase

      next_s.rdata = 16'h0000;
      if (req.rd) begin
         case (req.addr)
            ADDR_STATUS: next_s.rdata = {12'h000, s.status};
            ADDR_INRUSH: next_s.rdata = {8'h00, s.inrush};
            ADDR_CTRL: next_s.rdata = {8'h00, s.ctrl};
            ADDR_MAIN: next_s.rdata = {8'h00, s.main};
            ADDR_MEAS: next_s.rdata = {12'h000, ms_code};
            ADDR_HOURS: next_s.rdata = {2'b00, s.tmr.unit};
            ADDR_SETP: next_s.rdata = {2'b00, s.setp};
            ADDR_TERM: next_s.rdata = {8'h00, s.term_func};
            default: next_s.rdata = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{inrush: PCT_FULL, ctrl: PCT_FULL, main: PCT_FULL, setp: TMR_OFF,
                ms: MST_IDLE, term_func: TERM_RESET, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign nvm_save = s.save;
   assign nvm_out = s.tmr;
   assign dc_inject_out = s.dc_on;
   assign life_alarm_out = s.life;
   assign maint_timer_alarm_out = s.maint;
   assign maint_due_indication = s.maint;
   assign fan_fault_indication = s.status[ST_FAN];
   assign alarm_terminal_out = s.term;
endmodule : lmm_monitor

// ---- lmm_checker.sv ----
// Port assertions for the life and maintenance monitor
`timescale 1ns/1ps
module lmm_checker
   import lmm_pkg::*;
#(
   parameter int DC_CYC = DC_INJECT_CYC,
   parameter int SEC_CYCLES = SEC_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire lmm_req_t req,
   input wire logic [15:0] rdata,
   input wire logic [PIN_W-1:0] pins,
   input wire logic nvm_restore,
   input wire logic nvm_save,
   input wire lmm_nvm_t nvm_out,
   input wire logic dc_inject_out,
   input wire logic life_alarm_out,
   input wire logic maint_timer_alarm_out,
   input wire logic fan_fault_indication
);
   logic [25:0] dc_cnt;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dc_cnt <= 26'h0;
      end else begin
         dc_cnt <= dc_inject_out ? dc_cnt + 26'h1 : 26'h0;
      end
   end
   dc_len_a: assert property ($fell(dc_inject_out) |-> dc_cnt == 26'(DC_CYC))
      else $error("dc window length wrong");
   dc_start_a: assert property ($rose(dc_inject_out) |-> !$past(pins[PIN_MAINS], 3))
      else $error("dc window without power-off");
   fan_set_a: assert property ((|pins[PIN_FAN +: FAN_COUNT]) [*5]
      |-> fan_fault_indication && life_alarm_out) else $error("slow fan not flagged");
   fan_clear_a: assert property ((!(|pins[PIN_FAN +: FAN_COUNT])) [*5]
      |-> !fan_fault_indication) else $error("fan fault without slow fan");
   meas_code_a: assert property (req.rd && req.addr == ADDR_MEAS
      |=> rdata inside {16'h0, 16'h1, 16'h2, 16'h3, 16'h8, 16'h9}) else $error("bad measure code");
   maint_hold_a: assert property (maint_timer_alarm_out && !req.wr && !$past(req.wr)
      && !nvm_restore && !$past(nvm_restore) |=> maint_timer_alarm_out) else $error("alarm dropped");
   save_pulse_a: assert property (nvm_save |=> !nvm_save [*8])
      else $error("hour save too frequent");
   save_clamp_a: assert property (nvm_save |-> nvm_out.unit <= TMR_MAX && nvm_out.frac < 7'h64)
      else $error("timer beyond clamp");
   life_rel_a: assert property (fan_fault_indication |-> life_alarm_out)
      else $error("life alarm released early");
endmodule : lmm_checker
bind lmm_monitor lmm_checker #(.DC_CYC(DC_CYC), .SEC_CYCLES(SEC_CYCLES)) lmm_checker_i (
   .clk(clk), .rst(rst), .req(req), .rdata(rdata), .pins(pins), .nvm_restore(nvm_restore),
   .nvm_save(nvm_save), .nvm_out(nvm_out), .dc_inject_out(dc_inject_out),
   .life_alarm_out(life_alarm_out), .maint_timer_alarm_out(maint_timer_alarm_out),
   .fan_fault_indication(fan_fault_indication));

// ---- lmm_partner.sv ----
// Capacitor measurement front end answering after the DC window starts
`timescale 1ns/1ps
module lmm_partner (
   input wire logic clk,
   input wire logic rst,
   input wire logic dc_on,
   input wire logic [7:0] dly,
   input wire logic [7:0] pct,
   output logic done,
   output logic [7:0] pct_out,
   output logic fault
);
   logic dc_d;
   logic run;
   logic [7:0] cnt;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {dc_d, run, cnt, done, fault} <= '0;
      end else begin
         dc_d <= dc_on;
         done <= 1'b0;
         fault <= 1'b0;
         if (dc_on && !dc_d) begin
            run <= 1'b1;
            cnt <= 8'h0;
         end else if (run) begin
            cnt <= cnt + 8'h1;
            run <= cnt != dly;
            done <= cnt == dly && pct <= 8'h64;
            // Reading above full scale reports a failed measurement
            fault <= cnt == dly && pct > 8'h64;
         end
      end
   end
   assign pct_out = done ? pct : ~pct;
endmodule : lmm_partner

// ---- testbench.sv ----
// Self-checking bench for the life and maintenance monitor
`timescale 1ns/1ps
module testbench
   import lmm_pkg::*;
   ;
   logic clk = 1'b0;
   logic rst = 1'b1;
   lmm_req_t req = '0;
   logic [7:0] pins = 8'h08;
   logic tick = 1'b0;
   logic rest = 1'b0;
   lmm_nvm_t nin = '0;
   logic [7:0] dly = 8'h1e;
   logic [7:0] pct = 8'h0;
   logic [15:0] rdata, mst;
   logic done, flt, sav, dc, life, mnt, due, fan, term;
   logic [7:0] mpct;
   lmm_nvm_t nout;
   int n_errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic rd_d = 1'b0;
   logic [15:0] q[$];
   logic [31:0] seed = 32'h2298;
   logic [15:0] tbl[8] = '{16'h0, 16'h64, 16'h64, 16'h64, 16'h0, 16'h0, 16'h270f, 16'h0};
   always #12.5 clk = ~clk;
   lmm_monitor #(.DC_CYC(20), .SEC_CYCLES(4)) lmm_monitor_i (.clk(clk), .rst(rst), .req(req),
      .rdata(rdata), .pins(pins), .ctrl_cap_wear_tick(tick), .meas_done(done), .meas_pct(mpct),
      .meas_fault(flt), .nvm_restore(rest), .nvm_in(nin), .nvm_save(sav), .nvm_out(nout),
      .dc_inject_out(dc), .life_alarm_out(life), .maint_timer_alarm_out(mnt),
      .maint_due_indication(due), .fan_fault_indication(fan), .alarm_terminal_out(term));
   lmm_partner lmm_partner_i (.clk(clk), .rst(rst), .dc_on(dc), .dly(dly), .pct(pct),
      .done(done), .pct_out(mpct), .fault(flt));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      if (!w) q.push_back(d);
      @(posedge clk);
      req <= '0;
   endtask : bus
   task automatic restore(input logic [13:0] u, input logic [6:0] f);
      @(posedge clk);
      rest <= 1'b1;
      nin <= '{unit: u, frac: f};
      @(posedge clk);
      rest <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : restore
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge clk) begin
      rd_d <= req.rd;
      if (rd_d === 1'b1) chk(rdata, q.pop_front());
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 8; i++) bus(0, 4'(i), tbl[i]);
      bus(0, 4'h8, 16'h0);
      bus(1, ADDR_INRUSH, 16'h5);
      bus(0, ADDR_INRUSH, 16'h64);
      $display("test reset done");
      repeat (3334) begin
         @(posedge clk);
         pins <= 8'h0f;
         @(posedge clk);
         pins <= 8'h08;
      end
      // Last pulse crosses the block; let it settle
      repeat (2) @(posedge clk);
      bus(0, ADDR_INRUSH, 16'h63);
      pins <= 8'h88;
      repeat (6) @(negedge clk);
      chk({14'h0, fan, life}, 16'h3);
      bus(0, ADDR_STATUS, 16'h4);
      pins <= 8'h08;
      repeat (6) @(negedge clk);
      chk({15'h0, life}, 16'h0);
      $display("test inrush and fan done");
      seed = lfsr(seed);
      pct <= 8'(seed % 101);
      bus(1, ADDR_MEAS, 16'h2);
      bus(0, ADDR_MEAS, 16'h0);
      bus(1, ADDR_MEAS, 16'h1);
      bus(0, ADDR_MEAS, 16'h1);
      pins <= 8'h00;
      for (int i = 0; i < 20 && dc !== 1'b1; i++) @(negedge clk);
      chk({15'h0, dc}, 16'h1);
      bus(0, ADDR_MEAS, 16'h2);
      repeat (60) @(posedge clk);
      pins <= 8'h08;
      mst = {14'h0, pct <= 8'h55, 1'b0};
      bus(0, ADDR_MEAS, 16'h3);
      bus(0, ADDR_MAIN, {8'h0, pct});
      bus(0, ADDR_STATUS, mst);
      dly <= 8'hc8;
      bus(1, ADDR_MEAS, 16'h1);
      pins <= 8'h00;
      repeat (40) @(posedge clk);
      pins <= 8'h08;
      bus(0, ADDR_MEAS, 16'h2);
      pins <= 8'h28;
      repeat (6) @(posedge clk);
      bus(0, ADDR_MEAS, 16'h8);
      repeat (200) @(posedge clk);
      bus(0, ADDR_MEAS, 16'h8);
      pins <= 8'h08;
      // Out-of-range reading ends in the error code
      pct <= 8'hff;
      dly <= 8'h1e;
      bus(1, ADDR_MEAS, 16'h1);
      pins <= 8'h00;
      repeat (50) @(posedge clk);
      pins <= 8'h08;
      bus(0, ADDR_MEAS, 16'h9);
      $display("test measurement done");
      repeat (90) begin
         @(posedge clk);
         tick <= 1'b1;
         @(posedge clk);
         tick <= 1'b0;
      end
      bus(0, ADDR_CTRL, 16'ha);
      bus(0, ADDR_STATUS, mst);
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      bus(0, ADDR_CTRL, 16'h9);
      bus(0, ADDR_STATUS, mst | 16'h1);
      chk({15'h0, life}, 16'h1);
      bus(1, ADDR_TERM, {8'h0, TERM_LIFE_NEG});
      repeat (3) @(negedge clk);
      chk({15'h0, term}, 16'h0);
      bus(1, ADDR_TERM, {8'h0, TERM_LIFE_POS});
      repeat (3) @(negedge clk);
      chk({15'h0, term}, 16'h1);
      $display("test control capacitor done");
      bus(1, ADDR_SETP, 16'h5);
      restore(14'h5, 7'h0);
      chk({14'h0, mnt, due}, 16'h3);
      bus(0, ADDR_HOURS, 16'h5);
      bus(1, ADDR_TERM, {8'h0, TERM_MAINT_POS});
      repeat (3) @(negedge clk);
      chk({15'h0, term}, 16'h1);
      bus(1, ADDR_TERM, {8'h0, TERM_MAINT_NEG});
      repeat (3) @(negedge clk);
      chk({15'h0, term}, 16'h0);
      bus(1, ADDR_SETP, 16'h270f);
      repeat (3) @(negedge clk);
      chk({14'h0, mnt, term}, 16'h1);
      bus(1, ADDR_HOURS, 16'h3);
      bus(0, ADDR_HOURS, 16'h5);
      bus(1, ADDR_HOURS, 16'h0);
      bus(0, ADDR_HOURS, 16'h0);
      restore(14'h7, 7'h63);
      for (int i = 0; i < 16000 && sav !== 1'b1; i++) @(negedge clk);
      chk({2'h0, nout.unit}, 16'h8);
      bus(0, ADDR_HOURS, 16'h8);
      restore(14'h270e, 7'h63);
      for (int i = 0; i < 16000 && sav !== 1'b1; i++) @(negedge clk);
      bus(0, ADDR_HOURS, 16'h270e);
      $display("test timer done");
      tally_and_finish();
   end
endmodule : testbench
